// File: cdsg_gen.sv
// complementary dead-band generator with auto-shutdown and AXI4-Lite registers
//
// Behaviour
// RULE_01: two separate six-bit counters time rising and falling dead bands; code shares one counter, cnt_q, for both.
// RULE_02: dead band counts clock periods from zero up to the programmed value.
// RULE_03: rising input edge turns B off now, A on after rise dead band.
// RULE_04: falling input edge turns A off now, B on after fall dead band.
// RULE_05: each dead band is programmable from zero to sixty-four counts; code registers hold zero to 63.
// RULE_06: zero count means no delay; other output turns on with the edge.
// RULE_07: input pulse shorter than dead band keeps the waiting output off.
// RULE_08: edge sampling may add up to one clock period of delay; code's three-stage synchroniser adds two to three periods.
// RULE_09: software setting shutdown flag enters shutdown; holds while flag set.
// RULE_10: with auto-restart, software shutdown clears itself; resume at next rise; code keeps ase_q clear when the same write sets ars_q, so no shutdown occurs.
// RULE_11: enabled external shutdown forces overrides at once and sets flag.
// RULE_12: comparator and fault sources each have an enable, any combination.
// RULE_13: comparator active high, fault pin active low.
// RULE_14: shutdown is level sensitive; stays while an enabled source is active.
// RULE_15: overrides are driven during shutdown and ignore polarity; code's 00 inactive code still drives the polarity bit (pola_q, polb_q).
// RULE_16: override codes: 11 high, 10 low, 01 tri-state, 00 inactive level.
// RULE_17: without auto-restart, software clear works only if sources inactive.
// RULE_18: overrides hold after flag clears until next rising input edge.
// RULE_19: with auto-restart, flag clears once all enabled sources are inactive.
// RULE_20: generator runs on its own clock and keeps working in sleep.
// RULE_21: with oscillator selected and generator active, keep oscillator on; code requests it only while in_q is high.
// RULE_22: software configures while disabled with shutdown set, then releases.
// RULE_23: a new edge during a running count abandons it and restarts.
`timescale 1ns/1ps
`include "cdsg_consts.svh"
module cdsg_gen
   import cdsg_pkg::*;
#(
   parameter int DB_W = 6
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // waveform sources selected by isel_q, plus the fault pin
   input wire logic comparator_async_output,
   input wire logic pwm1_in,
   input wire logic pwm2_in,
   input wire logic pwm3_in,
   input wire logic fault_input_pin_n,
   // outputs to the power switch drivers, plus the oscillator request
   output logic output_a,
   output logic output_a_oe,
   output logic output_b,
   output logic output_b_oe,
   output logic osc_keep_alive
);

   // registers
   logic en_q, oeb_q, oea_q, polb_q, pola_q, cs_q;
   logic [1:0] ovb_q, ova_q;
   logic [2:0] isel_q;
   logic ase_q, ars_q, cmp_en_q, flt_en_q;
   logic [DB_W-1:0] rise_deadband_count, fall_deadband_count;
   // bus handshake state
   logic aw_hold_q, w_hold_q;
   logic [7:0] aw_q;
   logic [31:0] w_q;
   logic [3:0] ws_q;
   // synchronisers: three stages, change taken when 2nd and 3rd agree
   logic [2:0] in_sync_q, cmp_sync_q, flt_sync_q;
   logic in_q, cmp_q, flt_n_q;
   cdsg_state_t state_q;
   logic [DB_W-1:0] cnt_q;
   logic hold_ov_q;
   logic a_raw_q, b_raw_q;

   // selected raw input source
   logic src_raw;
   always_comb
   begin
      case (isel_q)
         3'h0: src_raw = comparator_async_output;
         3'h2: src_raw = pwm1_in;
         3'h3: src_raw = pwm2_in;
         3'h4: src_raw = pwm3_in;
         default: src_raw = 1'b0;
      endcase
   end

   // pin inputs cross into aclk; only stage two feeds stage three
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         in_sync_q <= 3'h0;
         cmp_sync_q <= 3'h0;
         flt_sync_q <= 3'h7;
         in_q <= 1'b0;
         cmp_q <= 1'b0;
         flt_n_q <= 1'b1;
      end
      else if (clk_en)
      begin
         in_sync_q <= {in_sync_q[1:0], src_raw};
         cmp_sync_q <= {cmp_sync_q[1:0], comparator_async_output};
         flt_sync_q <= {flt_sync_q[1:0], fault_input_pin_n};
         if (in_sync_q[1] == in_sync_q[2])
            in_q <= in_sync_q[2]; // RULE_08
         if (cmp_sync_q[1] == cmp_sync_q[2])
            cmp_q <= cmp_sync_q[2];
         if (flt_sync_q[1] == flt_sync_q[2])
            flt_n_q <= flt_sync_q[2];
      end
   end

   // edge events on the filtered input
   logic in_d, rise_ev, fall_ev;
   always_comb
   begin
      in_d = in_q;
      if (in_sync_q[1] == in_sync_q[2])
         in_d = in_sync_q[2];
   end
   assign rise_ev = in_d & ~in_q;
   assign fall_ev = ~in_d & in_q;

   // external shutdown demand, level sensitive
   logic ext_sd;
   assign ext_sd = (cmp_en_q & cmp_q) | (flt_en_q & ~flt_n_q); // RULE_12 RULE_13 RULE_14

   // bus write decode
   logic wr_go;
   assign wr_go = aw_hold_q & w_hold_q & ~s_axi_bvalid;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a[7:2] == ofs[7:2]);
   endfunction

   // write address/data capture in either order, response after both
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         aw_q <= 8'h00;
         w_q <= 32'h0000_0000;
         ws_q <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `CDSG_RESP_OKAY;
      end
      else if (clk_en)
      begin
         s_axi_awready <= ~aw_hold_q & ~s_axi_awready & ~s_axi_bvalid;
         s_axi_wready <= ~w_hold_q & ~s_axi_wready & ~s_axi_bvalid;
         if (s_axi_awvalid & s_axi_awready)
         begin
            aw_hold_q <= 1'b1;
            aw_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready)
         begin
            w_hold_q <= 1'b1;
            w_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_go)
         begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (hit(aw_q, `CDSG_MAIN_CTRL_OFS) | hit(aw_q, `CDSG_INPUT_SEL_OFS)
               | hit(aw_q, `CDSG_SHDN_CTRL_OFS) | hit(aw_q, `CDSG_RISE_DB_OFS)
               | hit(aw_q, `CDSG_FALL_DB_OFS) | hit(aw_q, `CDSG_STATUS_OFS))
               ? `CDSG_RESP_OKAY : `CDSG_RESP_SLVERR;
         end
         else if (s_axi_bvalid & s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // configuration registers; only byte lane 0 carries fields
   logic wr0;
   assign wr0 = wr_go & ws_q[0];
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         {en_q, oeb_q, oea_q, polb_q, pola_q, cs_q} <= 6'h00;
         ovb_q <= 2'h0;
         ova_q <= 2'h0;
         isel_q <= 3'h0;
         ars_q <= 1'b0;
         cmp_en_q <= 1'b0;
         flt_en_q <= 1'b0;
         rise_deadband_count <= `CDSG_DB_RESET;
         fall_deadband_count <= `CDSG_DB_RESET;
      end
      else if (clk_en && wr0)
      begin
         if (hit(aw_q, `CDSG_MAIN_CTRL_OFS))
         begin
            en_q <= w_q[`CDSG_EN_BIT];
            oeb_q <= w_q[6];
            oea_q <= w_q[5];
            polb_q <= w_q[`CDSG_POLB_BIT];
            pola_q <= w_q[`CDSG_POLA_BIT];
            cs_q <= w_q[0];
         end
         if (hit(aw_q, `CDSG_INPUT_SEL_OFS))
         begin
            ovb_q <= w_q[`CDSG_OVB_LSB +: 2];
            ova_q <= w_q[`CDSG_OVA_LSB +: 2];
            isel_q <= w_q[`CDSG_ISEL_LSB +: 3];
         end
         if (hit(aw_q, `CDSG_SHDN_CTRL_OFS))
         begin
            ars_q <= w_q[`CDSG_ARS_BIT];
            cmp_en_q <= w_q[`CDSG_CMPEN_BIT];
            flt_en_q <= w_q[`CDSG_FLTEN_BIT];
         end
         if (hit(aw_q, `CDSG_RISE_DB_OFS))
            rise_deadband_count <= w_q[DB_W-1:0]; // RULE_05
         if (hit(aw_q, `CDSG_FALL_DB_OFS))
            fall_deadband_count <= w_q[DB_W-1:0]; // RULE_05
      end
   end

   // shutdown event flag: hardware set wins over software clear
   logic sw_ase_wr;
   assign sw_ase_wr = wr0 & hit(aw_q, `CDSG_SHDN_CTRL_OFS);
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ase_q <= 1'b0;
      else if (clk_en)
      begin
         if (ext_sd)
            ase_q <= 1'b1; // RULE_11 RULE_14
         else if (sw_ase_wr && w_q[`CDSG_ASE_BIT])
            ase_q <= ~w_q[`CDSG_ARS_BIT]; // RULE_09 RULE_10
         else if (sw_ase_wr)
            ase_q <= 1'b0; // RULE_17
         else if (ars_q)
            ase_q <= 1'b0; // RULE_19 RULE_10
      end
   end

   // overrides stay until the first rising event after the flag clears
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         hold_ov_q <= 1'b1;
      else if (clk_en)
      begin
         if (ase_q || ext_sd || !en_q)
            hold_ov_q <= 1'b1; // RULE_09
         else if (rise_ev)
            hold_ov_q <= 1'b0; // RULE_18
      end
   end

   // dead-band sequencer, one counter reused for whichever edge is live
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_q <= CDSG_IDLE;
         cnt_q <= '0;
         a_raw_q <= 1'b0;
         b_raw_q <= 1'b0;
      end
      else if (clk_en)
      begin
         if (!en_q)
         begin
            state_q <= CDSG_IDLE;
            a_raw_q <= 1'b0;
            b_raw_q <= 1'b0;
         end
         else if (rise_ev)
         begin
            b_raw_q <= 1'b0; // RULE_03 RULE_23
            cnt_q <= '0;
            a_raw_q <= (rise_deadband_count == '0); // RULE_06
            state_q <= (rise_deadband_count == '0) ? CDSG_HIGH : CDSG_RISE_WAIT;
         end
         else if (fall_ev)
         begin
            a_raw_q <= 1'b0; // RULE_04 RULE_07 RULE_23
            cnt_q <= '0;
            b_raw_q <= (fall_deadband_count == '0); // RULE_06
            state_q <= (fall_deadband_count == '0) ? CDSG_IDLE : CDSG_FALL_WAIT;
         end
         else
         begin
            case (state_q)
               CDSG_RISE_WAIT:
               begin
                  cnt_q <= cnt_q + 1'b1; // RULE_01 RULE_02
                  if (cnt_q + 1'b1 == rise_deadband_count)
                  begin
                     a_raw_q <= 1'b1; // RULE_03
                     state_q <= CDSG_HIGH;
                  end
               end
               CDSG_FALL_WAIT:
               begin
                  cnt_q <= cnt_q + 1'b1; // RULE_01 RULE_02
                  if (cnt_q + 1'b1 == fall_deadband_count)
                  begin
                     b_raw_q <= 1'b1; // RULE_04
                     state_q <= CDSG_IDLE;
                  end
               end
               CDSG_HIGH: state_q <= CDSG_HIGH;
               CDSG_IDLE: state_q <= CDSG_IDLE;
               default: state_q <= CDSG_IDLE;
            endcase
         end
      end
   end

   // pin drive for one output; polarity is ignored by forced levels
   function automatic cdsg_pin_t drive(input logic raw, input logic pol, input logic oe,
      input logic ov_on, input logic [1:0] ov);
      cdsg_pin_t p;
      p.oe = oe;
      p.val = raw ^ pol;
      if (ov_on)
      begin
         case (cdsg_ov_t'(ov))
            CDSG_OV_HIGH: p.val = 1'b1; // RULE_15 RULE_16
            CDSG_OV_LOW: p.val = 1'b0; // RULE_16
            CDSG_OV_TRISTATE: p.oe = 1'b0; // RULE_16
            default: p.val = pol; // inactive level keeps polarity
         endcase
      end
      return p;
   endfunction

   cdsg_pin_t pa_d, pb_d;
   assign pa_d = drive(a_raw_q, pola_q, oea_q & en_q, hold_ov_q | ext_sd, ova_q);
   assign pb_d = drive(b_raw_q, polb_q, oeb_q & en_q, hold_ov_q | ext_sd, ovb_q);

   // registered pins; oscillator request while enabled with cs_q set and in_q high
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         output_a <= 1'b0;
         output_a_oe <= 1'b0;
         output_b <= 1'b0;
         output_b_oe <= 1'b0;
         osc_keep_alive <= 1'b0;
      end
      else if (clk_en)
      begin
         output_a <= pa_d.val; // RULE_11
         output_a_oe <= pa_d.oe;
         output_b <= pb_d.val;
         output_b_oe <= pb_d.oe;
         osc_keep_alive <= en_q & cs_q & in_q; // RULE_20 RULE_21
      end
   end

   // read channel, one read at a time
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `CDSG_RESP_OKAY;
      end
      else if (clk_en)
      begin
         s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
         if (s_axi_arvalid & s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `CDSG_RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            if (hit(s_axi_araddr, `CDSG_MAIN_CTRL_OFS))
               s_axi_rdata[7:0] <= {en_q, oeb_q, oea_q, polb_q, pola_q, 2'b00, cs_q};
            else if (hit(s_axi_araddr, `CDSG_INPUT_SEL_OFS))
               s_axi_rdata[7:0] <= {ovb_q, ova_q, 1'b0, isel_q};
            else if (hit(s_axi_araddr, `CDSG_SHDN_CTRL_OFS))
               s_axi_rdata[7:0] <= {ase_q, ars_q, 3'b000, cmp_en_q, flt_en_q, 1'b0};
            else if (hit(s_axi_araddr, `CDSG_RISE_DB_OFS))
               s_axi_rdata[DB_W-1:0] <= rise_deadband_count;
            else if (hit(s_axi_araddr, `CDSG_FALL_DB_OFS))
               s_axi_rdata[DB_W-1:0] <= fall_deadband_count;
            else if (hit(s_axi_araddr, `CDSG_STATUS_OFS))
               s_axi_rdata[7:0] <= {2'b00, hold_ov_q, ext_sd, state_q, b_raw_q, a_raw_q};
            else
               s_axi_rresp <= `CDSG_RESP_SLVERR;
         end
         else if (s_axi_rvalid & s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // checks; RULE_22 is software's duty and not checked here
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_never_overlap: assert property (clk_en && !hold_ov_q && !ext_sd |-> !(a_raw_q && b_raw_q)) // RULE_03
      else $error("both outputs on together");
   a_rise_b_off: assert property (clk_en && en_q && rise_ev |=> !b_raw_q) // RULE_03
      else $error("b not off after rise");
   a_fall_a_off: assert property (clk_en && en_q && fall_ev |=> !a_raw_q) // RULE_04
      else $error("a not off after fall");
   a_zero_db_rise: assert property (clk_en && en_q && rise_ev && rise_deadband_count == '0
      |=> a_raw_q) // RULE_06
      else $error("zero rise band delayed a");
   a_rise_count: assert property (clk_en && en_q && rise_ev && rise_deadband_count == 6'h03
      ##1 (clk_en && !fall_ev && !rise_ev) [*3] |=> a_raw_q) // RULE_02
      else $error("rise band length wrong");
   a_rise_no_early: assert property (clk_en && en_q && rise_ev && rise_deadband_count == 6'h03
      |=> !a_raw_q) // RULE_07
      else $error("a rose early");
   a_ext_sets_flag: assert property (clk_en && ext_sd |=> ase_q) // RULE_11
      else $error("external shutdown did not set flag");
   a_override_high: assert property (clk_en && ext_sd && ovb_q == 2'b11 && oeb_q && en_q
      |=> output_b) // RULE_15
      else $error("override high not driven");
   a_override_tri: assert property (clk_en && ext_sd && ovb_q == 2'b01 |=> !output_b_oe) // RULE_16
      else $error("override tristate not applied");
   a_hold_after_clr: assert property (clk_en && $fell(ase_q) && !rise_ev && !ext_sd
      |=> hold_ov_q) // RULE_18
      else $error("overrides dropped before rise");
   a_autorestart_clr: assert property (clk_en && ars_q && ase_q && !ext_sd && !sw_ase_wr
      |=> !ase_q) // RULE_19
      else $error("auto restart did not clear flag");

   c_shutdown: cover property (clk_en && ext_sd ##1 ase_q);
   c_rise_wait: cover property (state_q == CDSG_RISE_WAIT ##[1:70] state_q == CDSG_HIGH);
   c_short_pulse: cover property (state_q == CDSG_RISE_WAIT && fall_ev);
   c_restart: cover property ($fell(hold_ov_q));

endmodule // cdsg_gen

// File: cdsg_consts.svh
// register offsets, field positions, response codes and reset values for the generator
`ifndef CDSG_CONSTS_SVH
`define CDSG_CONSTS_SVH
`define CDSG_MAIN_CTRL_OFS 8'h00
`define CDSG_INPUT_SEL_OFS 8'h04
`define CDSG_SHDN_CTRL_OFS 8'h08
`define CDSG_RISE_DB_OFS 8'h0C
`define CDSG_FALL_DB_OFS 8'h10
`define CDSG_STATUS_OFS 8'h14
`define CDSG_EN_BIT 7
`define CDSG_POLB_BIT 4
`define CDSG_POLA_BIT 3
`define CDSG_OVB_LSB 6
`define CDSG_OVA_LSB 4
`define CDSG_ISEL_LSB 0
`define CDSG_ASE_BIT 7
`define CDSG_ARS_BIT 6
`define CDSG_CMPEN_BIT 2
`define CDSG_FLTEN_BIT 1
`define CDSG_RESP_OKAY 2'b00
`define CDSG_RESP_SLVERR 2'b10
`define CDSG_DB_RESET 6'h00
`define CDSG_CTRL_RESET 8'h00
`endif

// File: cdsg_pkg.sv
// types shared by the complementary dead-band generator
package cdsg_pkg;
   // override selection for one output during shutdown
   typedef enum logic [1:0] {
      CDSG_OV_INACTIVE = 2'b00,
      CDSG_OV_TRISTATE = 2'b01,
      CDSG_OV_LOW = 2'b10,
      CDSG_OV_HIGH = 2'b11
   } cdsg_ov_t;
   // dead-band sequencer states, gray along rise/fall path
   typedef enum logic [1:0] {
      CDSG_IDLE = 2'b00,
      CDSG_RISE_WAIT = 2'b01,
      CDSG_HIGH = 2'b11,
      CDSG_FALL_WAIT = 2'b10
   } cdsg_state_t;
   // one output pin as value plus enable
   typedef struct packed {
      logic val;
      logic oe;
   } cdsg_pin_t;
endpackage

// File: cdsg_switch_model.sv
// behavioural model of the two power switch drivers on the outputs
`timescale 1ns/1ps
module cdsg_switch_model
(
   input wire logic clk,
   input wire logic a_val,
   input wire logic a_oe,
   input wire logic b_val,
   input wire logic b_oe,
   output logic overlap
);
   logic a_q;
   logic b_q;
   logic pin_a;
   logic pin_b;
   // last level each pin was driven to
   always_ff @(posedge clk)
   begin
      if (a_oe)
         a_q <= a_val;
      if (b_oe)
         b_q <= b_val;
   end
   // gate lines have no pull, so a released pin drifts away from its last level
   assign pin_a = a_oe ? a_val : ~a_q;
   assign pin_b = b_oe ? b_val : ~b_q;
   // both switches driven on means shoot-through
   assign overlap = a_oe & b_oe & pin_a & pin_b;
endmodule // cdsg_switch_model

// File: complementary_deadband_shutdown_tb.sv
// self-checking bench for the complementary dead-band generator
`timescale 1ns/1ps
`include "cdsg_consts.svh"
module complementary_deadband_shutdown_tb;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic comparator_async_output = 1'h0, pwm1_in = 1'h0, fault_input_pin_n = 1'h1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [31:0] s_axi_rdata, rd_q;
   logic output_a, output_a_oe, output_b, output_b_oe, osc_keep_alive, overlap;
   int error_cnt = 0;
   int compares = 0;

   cdsg_gen i_cdsg_gen
   (
      .aclk, .aresetn, .clk_en(1'h1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .comparator_async_output,
      .pwm1_in, .pwm2_in(1'h0), .pwm3_in(1'h0), .fault_input_pin_n, .output_a,
      .output_a_oe, .output_b, .output_b_oe, .osc_keep_alive
   );

   cdsg_switch_model i_cdsg_switch_model
   (
      .clk(aclk), .a_val(output_a), .a_oe(output_a_oe), .b_val(output_b),
      .b_oe(output_b_oe), .overlap
   );

   // 50 MHz clock
   initial
   begin
      forever #10 aclk = ~aclk;
   end

   // shoot-through never allowed
   always @(posedge aclk)
   begin
      if (aresetn && overlap === 1'h1)
      begin
         error_cnt++;
         $display("[FAIL] overlap expected 0 seen 1");
      end
   end

   // verdict and end of run
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   // spent bound ends run
   task automatic bound(input int n, input int lim);
      if (n >= lim)
      begin
         error_cnt++;
         $display("[FAIL] wait expected done seen timeout");
         tally_and_finish();
      end
   endtask

   // write: aw and w together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid)
         begin
            r = s_axi_bresp;
            s_axi_bready <= 1'h0;
            break;
         end
      end
      bound(n, 50);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid)
         begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'h0;
            break;
         end
      end
      bound(n, 50);
   endtask

   task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] e);
      rd(a, rd_q, rsp);
      chk(what, e, rd_q);
      chk("read resp", `CDSG_RESP_OKAY, rsp);
   endtask

   // pins reach pair in bounded time
   task automatic wait_ab(input logic ea, input logic eb);
      int n;
      for (n = 0; n < 20; n++)
      begin
         @(posedge aclk);
         if (output_a === ea && output_b === eb) break;
      end
      chk("pins a b", {ea, eb}, {output_a, output_b});
   endtask

   // one edge; cycles to other off and this on
   task automatic one_edge(input logic lvl, output int t, output int toff);
      toff = 0;
      @(posedge aclk);
      pwm1_in <= lvl;
      for (t = 1; t < 120; t++)
      begin
         @(posedge aclk);
         if (toff == 0 && (lvl ? output_b : output_a) === 1'h0) toff = t;
         if ((lvl ? output_a : output_b) === 1'h1) break;
      end
      bound(t, 120);
   endtask

   // reset values, width, status, unmapped
   task automatic t_regs;
      int i;
      for (i = 0; i < 5; i++)
         rdchk("reset value", 8'(4 * i), 32'h0);
      rdchk("stat rst", `CDSG_STATUS_OFS, 32'h20);
      wr(`CDSG_STATUS_OFS, 32'hFF, rsp);
      rdchk("stat ro", `CDSG_STATUS_OFS, 32'h20);
      wr(`CDSG_RISE_DB_OFS, 32'hFF, rsp);
      rdchk("rise width", `CDSG_RISE_DB_OFS, 32'h3F);
      wr(8'h18, 32'h1, rsp);
      chk("unmap wresp", `CDSG_RESP_SLVERR, rsp);
      rd(8'h18, rd_q, rsp);
      chk("unmap rresp", `CDSG_RESP_SLVERR, rsp);
      chk("unmap rdata", 32'h0, rd_q);
   endtask

   // dead bands, zero to largest
   task automatic t_dead;
      int r0, f0, t, toff, i;
      int v[3] = '{1, 3, 63};
      wr(`CDSG_SHDN_CTRL_OFS, 32'h80, rsp);
      wr(`CDSG_RISE_DB_OFS, 32'h0, rsp);
      wr(`CDSG_FALL_DB_OFS, 32'h0, rsp);
      wr(`CDSG_INPUT_SEL_OFS, 32'h02, rsp);
      wr(`CDSG_MAIN_CTRL_OFS, 32'hE0, rsp);
      wr(`CDSG_SHDN_CTRL_OFS, 32'h0, rsp);
      repeat (2)
      begin
         one_edge(1'h1, r0, toff);
         one_edge(1'h0, f0, toff);
      end
      chk("zero db", f0, toff);
      for (i = 0; i < 3; i++)
      begin
         wr(`CDSG_RISE_DB_OFS, v[i], rsp);
         wr(`CDSG_FALL_DB_OFS, v[i], rsp);
         one_edge(1'h1, t, toff);
         chk("rise db", r0 + v[i], t);
         chk("b off", r0, toff);
         one_edge(1'h0, t, toff);
         chk("fall db", f0 + v[i], t);
         chk("a off", f0, toff);
      end
   endtask

   // pulse shorter than rise count
   task automatic t_short;
      int k;
      wr(`CDSG_RISE_DB_OFS, 32'h0A, rsp);
      wr(`CDSG_FALL_DB_OFS, 32'h0, rsp);
      @(posedge aclk);
      pwm1_in <= 1'h1;
      repeat (4) @(posedge aclk);
      pwm1_in <= 1'h0;
      for (k = 0; k < 30; k++)
      begin
         @(posedge aclk);
         chk("a short", 1'h0, output_a);
      end
      chk("b short", 1'h1, output_b);
   endtask

   // external shutdown and restart
   task automatic t_ext;
      int t, toff;
      wr(`CDSG_RISE_DB_OFS, 32'h0, rsp);
      wr(`CDSG_INPUT_SEL_OFS, 32'hE2, rsp);
      wr(`CDSG_SHDN_CTRL_OFS, 32'h04, rsp);
      one_edge(1'h1, t, toff);
      comparator_async_output <= 1'h1;
      wait_ab(1'h0, 1'h1);
      rdchk("cmp flag", `CDSG_SHDN_CTRL_OFS, 32'h84);
      wr(`CDSG_SHDN_CTRL_OFS, 32'h04, rsp);
      rdchk("clr active", `CDSG_SHDN_CTRL_OFS, 32'h84);
      comparator_async_output <= 1'h0;
      repeat (6) @(posedge aclk);
      wr(`CDSG_SHDN_CTRL_OFS, 32'h04, rsp);
      rdchk("clr idle", `CDSG_SHDN_CTRL_OFS, 32'h04);
      repeat (10) @(posedge aclk);
      chk("ov held", 2'h1, {output_a, output_b});
      pwm1_in <= 1'h0;
      repeat (6) @(posedge aclk);
      chk("fall held", 2'h1, {output_a, output_b});
      one_edge(1'h1, t, toff);
      wr(`CDSG_SHDN_CTRL_OFS, 32'h02, rsp);
      comparator_async_output <= 1'h1;
      repeat (8) @(posedge aclk);
      chk("src off", 2'h2, {output_a, output_b});
      comparator_async_output <= 1'h0;
      fault_input_pin_n <= 1'h0;
      wait_ab(1'h0, 1'h1);
      fault_input_pin_n <= 1'h1;
      repeat (6) @(posedge aclk);
      wr(`CDSG_SHDN_CTRL_OFS, 32'h0, rsp);
      rdchk("flt clr", `CDSG_SHDN_CTRL_OFS, 32'h0);
   endtask

   // override codes, a inverted
   task automatic t_codes;
      int c;
      logic [1:0] e[4] = '{2'h3, 2'h0, 2'h2, 2'h3};
      wr(`CDSG_SHDN_CTRL_OFS, 32'h80, rsp);
      wr(`CDSG_MAIN_CTRL_OFS, 32'hE8, rsp);
      for (c = 0; c < 4; c++)
      begin
         wr(`CDSG_INPUT_SEL_OFS, 32'h82 | 32'(c << 4), rsp);
         repeat (20) @(posedge aclk);
         chk("a override", e[c], {output_a_oe, output_a & output_a_oe});
         chk("b override", 2'h2, {output_b_oe, output_b});
      end
      rdchk("sw flag", `CDSG_SHDN_CTRL_OFS, 32'h80);
      wr(`CDSG_MAIN_CTRL_OFS, 32'hE0, rsp);
      wr(`CDSG_INPUT_SEL_OFS, 32'hE2, rsp);
      wr(`CDSG_SHDN_CTRL_OFS, 32'h0, rsp);
   endtask

   // automatic restart; low input must pass the pin filter
   task automatic t_auto;
      int t, toff;
      wr(`CDSG_SHDN_CTRL_OFS, 32'h44, rsp);
      pwm1_in <= 1'h0;
      repeat (6) @(posedge aclk);
      one_edge(1'h1, t, toff);
      comparator_async_output <= 1'h1;
      wait_ab(1'h0, 1'h1);
      rdchk("auto set", `CDSG_SHDN_CTRL_OFS, 32'hC4);
      comparator_async_output <= 1'h0;
      repeat (10) @(posedge aclk);
      rdchk("auto clr", `CDSG_SHDN_CTRL_OFS, 32'h44);
      chk("auto held", 2'h1, {output_a, output_b});
      pwm1_in <= 1'h0;
      repeat (6) @(posedge aclk);
      one_edge(1'h1, t, toff);
      wr(`CDSG_SHDN_CTRL_OFS, 32'hC0, rsp);
      rdchk("sw self clr", `CDSG_SHDN_CTRL_OFS, 32'h40);
      wr(`CDSG_SHDN_CTRL_OFS, 32'h0, rsp);
   endtask

   // oscillator request
   task automatic t_osc;
      chk("osc sysclk", 1'h0, osc_keep_alive);
      wr(`CDSG_MAIN_CTRL_OFS, 32'hE1, rsp);
      repeat (8) @(posedge aclk);
      chk("osc in hi", 1'h1, osc_keep_alive);
      pwm1_in <= 1'h0;
      repeat (8) @(posedge aclk);
      chk("osc in lo", 1'h0, osc_keep_alive);
   endtask

   // four reset cycles, then scenarios
   initial
   begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      t_regs();
      t_dead();
      t_short();
      t_ext();
      t_codes();
      t_auto();
      t_osc();
      tally_and_finish();
   end
endmodule // complementary_deadband_shutdown_tb
